// ---- adc_control_pin_logic.sv ----
// Control-pin logic: range, power-down, interface, conversion and read.
`timescale 1ns/1ps
import adc_ctl_pkg::*;

// Contract
// - Span high selects 10 V, low 5 V
// - Span change needs 80 us settle
// - Power-down low enters standby or shutdown
// - Shutdown powers all; standby keeps reference
// - Interface select picks parallel, serial, byte
// - Start inputs convert channel halves
// - Start rising edge holds and converts
// - Reads allowed whatever start levels are
// - Reset is asynchronous and held while high; here reset_pin passes two sync flops and acts on clock edges
// - Reset aborts conversion, data invalid
// - Reset during read zeroes output data
// - Parallel read strobe drives bus with select
// - Serial mode times on clock rising edge
// - Busy ignores both start inputs
// - Chip select rise floats data lines
module adc_control_pin_logic (
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire logic                    reset_pin,
    input  wire logic                    range_pin,
    input  wire logic                    power_down_n,
    input  wire logic                    interface_select,
    input  wire logic                    bit15_or_byte_select_in,
    input  wire logic                    msb_byte_first,
    input  wire logic                    conv_start_lo_half,
    input  wire logic                    conv_start_hi_half,
    input  wire logic                    chip_select_b,
    input  wire logic                    rd_b_or_sclk,
    input  wire logic [NUM_CH*DATA_W-1:0] sample_data,
    output logic                         range_10v,
    output logic                         settling,
    output adc_ctl_pkg::pwr_mode_t       pwr_mode,
    output adc_ctl_pkg::if_mode_t        if_mode,
    output logic                         hold_lo_half,
    output logic                         hold_hi_half,
    output logic                         busy,
    output logic                         data_invalid,
    output logic [DATA_W-1:0]            db_out,
    output logic [DATA_W-1:0]            db_oe_b,
    output logic                         dout_a,
    output logic                         dout_b,
    output logic                         dout_oe_b
);
    // ********************************************************
    // Synchronisers
    // ********************************************************
    logic s_rst;
    logic s_range;
    logic s_pdn;
    logic s_ifsel;
    logic s_bsel;
    logic s_hben;
    logic s_cva;
    logic s_cvb;
    logic s_cs_b;
    logic s_rd;

    localparam int NSYNC = 10;
    // Low-true pins reset high so no false edge follows reset.
    localparam logic [NSYNC-1:0] SYNC_IDLE = 10'h083;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] syn_out;

    assign raw_in = {reset_pin, range_pin, power_down_n, interface_select,
                     bit15_or_byte_select_in, msb_byte_first,
                     conv_start_lo_half, conv_start_hi_half,
                     chip_select_b, rd_b_or_sclk};
    assign {s_rst, s_range, s_pdn, s_ifsel, s_bsel, s_hben,
            s_cva, s_cvb, s_cs_b, s_rd} = syn_out;

    // sync all pins
    // Every pin crosses two flops before any logic looks at it.
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            sync2 #(.RST_VAL(SYNC_IDLE[gi])) u_sync (
                .clk   (clk),
                .rst_b (rst_b),
                .d     (raw_in[gi]),
                .q     (syn_out[gi])
            );
        end
    endgenerate

    // ********************************************************
    // State
    // ********************************************************
    typedef struct packed {
        logic                         range_10v;
        logic [CNT_W-1:0]             settle_cnt;
        logic                         settling;
        pwr_mode_t                    pwr;
        if_mode_t                     ifm;
        logic                         hold_lo;
        logic                         hold_hi;
        logic                         busy;
        logic                         invalid;
        logic                         cva_d;
        logic                         cvb_d;
        logic                         cs_d;
        logic                         rd_d;
        logic [NUM_CH*DATA_W-1:0]     out_regs;
        logic [2:0]                   ch;
        logic                         byte_sel;
        logic [3:0]                   bitc;
        logic [DATA_W-1:0]            db;
        logic [DATA_W-1:0]            db_oe_b;
        logic                         da;
        logic                         dbo;
        logic                         dout_oe_b;
    } top_state_t;

    top_state_t st_ff;
    top_state_t nxt_st;

    logic       tmr_lo_run;
    logic       tmr_hi_run;
    logic       tmr_lo_done;
    logic       tmr_hi_done;
    logic       start_lo;
    logic       start_hi;

    // Mode decode is used for both the bus direction and the read path.
    function automatic if_mode_t decode_if(input logic ifsel,
                                           input logic bsel);
        if (!ifsel) begin
            return IF_PARALLEL;
        end else if (!bsel) begin
            return IF_SERIAL;
        end else begin
            return IF_BYTE;
        end
    endfunction : decode_if

    // Picks one channel word out of the packed output registers.
    function automatic logic [DATA_W-1:0] word_of(
        input logic [NUM_CH*DATA_W-1:0] regs,
        input logic [2:0]               idx);
        return regs[idx*DATA_W +: DATA_W];
    endfunction : word_of

    assign start_lo = s_cva && !st_ff.cva_d && !st_ff.busy &&
                      st_ff.pwr == PWR_NORMAL;
    assign start_hi = s_cvb && !st_ff.cvb_d && !st_ff.busy &&
                      st_ff.pwr == PWR_NORMAL;

    conv_timer u_tmr_lo (
        .clk     (clk),
        .rst_b   (rst_b),
        .abort   (s_rst),
        .start   (start_lo),
        .running (tmr_lo_run),
        .done    (tmr_lo_done)
    );

    conv_timer u_tmr_hi (
        .clk     (clk),
        .rst_b   (rst_b),
        .abort   (s_rst),
        .start   (start_hi),
        .running (tmr_hi_run),
        .done    (tmr_hi_done)
    );

    // ********************************************************
    // Next-state logic
    // ********************************************************
    always_comb begin
        logic           cs_rise;
        logic           rd_fall;
        logic           sclk_rise;
        logic [DATA_W-1:0] w;
        cs_rise   = 1'b0;
        rd_fall   = 1'b0;
        sclk_rise = 1'b0;
        w         = '0;
        nxt_st    = st_ff;
        nxt_st.cva_d = s_cva;
        nxt_st.cvb_d = s_cvb;
        nxt_st.cs_d  = s_cs_b;
        nxt_st.rd_d  = s_rd;
        cs_rise   = s_cs_b && !st_ff.cs_d;
        rd_fall   = !s_rd && st_ff.rd_d;
        sclk_rise = s_rd && !st_ff.rd_d;

        nxt_st.range_10v = s_range;
        // settle timer
        // Flags the 80 us settle after a range change; starts are not gated on it.
        if (s_range != st_ff.range_10v) begin
            nxt_st.settling   = 1'b1;
            nxt_st.settle_cnt = CNT_W'(SETTLE_CYCLES - 1);
        end else if (st_ff.settle_cnt != '0) begin
            nxt_st.settle_cnt = st_ff.settle_cnt - 1'b1;
        end else begin
            nxt_st.settling = 1'b0;
        end

        if (s_pdn) begin
            nxt_st.pwr = PWR_NORMAL;
        end else if (s_range) begin
            nxt_st.pwr = PWR_SHUTDOWN;
        end else begin
            nxt_st.pwr = PWR_STANDBY;
        end

        nxt_st.ifm = decode_if(s_ifsel, s_bsel);

        // Hold and busy track the two conversion timers.
        if (start_lo) begin
            nxt_st.hold_lo = 1'b1;
        end else if (tmr_lo_done) begin
            nxt_st.hold_lo = 1'b0;
        end
        if (start_hi) begin
            nxt_st.hold_hi = 1'b1;
        end else if (tmr_hi_done) begin
            nxt_st.hold_hi = 1'b0;
        end
        // Busy holds until both halves have latched their results.
        nxt_st.busy = st_ff.busy ? (tmr_lo_run || tmr_hi_run) :
                      (tmr_lo_run || start_lo) && (tmr_hi_run || start_hi);
        if (start_lo || start_hi) begin
            nxt_st.invalid = 1'b0;
        end
        // Results latch only when each half finishes.
        for (int c = 0; c < HALF_CH; c++) begin
            if (tmr_lo_done) begin
                nxt_st.out_regs[c*DATA_W +: DATA_W] =
                    sample_data[c*DATA_W +: DATA_W];
            end
            if (tmr_hi_done) begin
                nxt_st.out_regs[(c+HALF_CH)*DATA_W +: DATA_W] =
                    sample_data[(c+HALF_CH)*DATA_W +: DATA_W];
            end
        end

        w = word_of(st_ff.out_regs, st_ff.ch);
        if (s_cs_b) begin
            nxt_st.ch       = CH_FIRST;
            nxt_st.byte_sel = BYTE_FIRST;
            nxt_st.bitc     = '0;
        end
        case (st_ff.ifm)
            IF_PARALLEL, IF_BYTE: begin
                // drive only under chip select and strobe
                nxt_st.dout_oe_b = 1'b1;
                if (!s_cs_b && !s_rd) begin
                    nxt_st.db_oe_b = '0;
                    if (st_ff.ifm == IF_PARALLEL) begin
                        nxt_st.db = w;
                    end else begin
                        nxt_st.db = {8'h00, (st_ff.byte_sel ^ !s_hben)
                                     ? w[7:0] : w[15:8]};
                    end
                end else begin
                    nxt_st.db_oe_b = '1;
                end
                // Advance after each strobe pulse ends.
                if (!s_cs_b && rd_fall && st_ff.db_oe_b == '0) begin
                    nxt_st.db_oe_b = '1;
                end
                if (!s_cs_b && sclk_rise) begin
                    if (st_ff.ifm == IF_BYTE && st_ff.byte_sel == BYTE_FIRST)
                    begin
                        nxt_st.byte_sel = ~BYTE_FIRST;
                    end else begin
                        nxt_st.byte_sel = BYTE_FIRST;
                        nxt_st.ch       = st_ff.ch + 1'b1;
                    end
                end
            end
            IF_SERIAL: begin
                nxt_st.db_oe_b   = '1;
                nxt_st.dout_oe_b = s_cs_b;
                if (!s_cs_b) begin
                    nxt_st.da  = st_ff.out_regs[
                        st_ff.ch*DATA_W + (BITS_PER_CH-1) - st_ff.bitc];
                    nxt_st.dbo = st_ff.out_regs[
                        (st_ff.ch+HALF_CH)*DATA_W + (BITS_PER_CH-1)
                        - st_ff.bitc];
                    if (sclk_rise) begin
                        nxt_st.bitc = st_ff.bitc + 1'b1;
                        if (st_ff.bitc == BIT_LAST &&
                            st_ff.ch != 3'(HALF_CH - 1)) begin
                            nxt_st.ch = st_ff.ch + 1'b1;
                        end
                    end
                end
            end
            default: begin
                nxt_st.db_oe_b   = '1;
                nxt_st.dout_oe_b = 1'b1;
            end
        endcase

        if (cs_rise) begin
            nxt_st.db_oe_b   = '1;
            nxt_st.dout_oe_b = 1'b1;
        end

        if (s_rst) begin
            nxt_st.invalid  = st_ff.invalid || st_ff.busy || tmr_lo_run ||
                              tmr_hi_run;
            nxt_st.hold_lo  = 1'b0;
            nxt_st.hold_hi  = 1'b0;
            nxt_st.busy     = 1'b0;
            nxt_st.ch       = CH_FIRST;
            nxt_st.bitc     = '0;
            nxt_st.byte_sel = BYTE_FIRST;
            nxt_st.out_regs = {NUM_CH{DATA_RESET}};
            nxt_st.db       = DATA_RESET;
            nxt_st.da       = 1'b0;
            nxt_st.dbo      = 1'b0;
        end
    end

    // Pin reset enters via a synchroniser; rst_b clears state at once.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '{pwr: PWR_NORMAL, ifm: IF_PARALLEL, db_oe_b: '1,
                       dout_oe_b: 1'b1, cs_d: 1'b1, rd_d: 1'b1,
                       default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign range_10v    = st_ff.range_10v;
    assign settling     = st_ff.settling;
    assign pwr_mode     = st_ff.pwr;
    assign if_mode      = st_ff.ifm;
    assign hold_lo_half = st_ff.hold_lo;
    assign hold_hi_half = st_ff.hold_hi;
    assign busy         = st_ff.busy;
    assign data_invalid = st_ff.invalid;
    assign db_out       = st_ff.db;
    assign db_oe_b      = st_ff.db_oe_b;
    assign dout_a       = st_ff.da;
    assign dout_b       = st_ff.dbo;
    assign dout_oe_b    = st_ff.dout_oe_b;
endmodule : adc_control_pin_logic

// ---- adc_ctl_checker.sv ----
// Concurrent checks on the converter control-pin logic ports.
`timescale 1ns/1ps
module adc_ctl_checker
    import adc_ctl_pkg::*;
(
    input wire logic                clk,
    input wire logic                rst_b,
    input wire logic                reset_pin,
    input wire logic                range_pin,
    input wire logic                power_down_n,
    input wire logic                interface_select,
    input wire logic                conv_start_lo_half,
    input wire logic                chip_select_b,
    input wire logic                rd_b_or_sclk,
    input wire logic                range_10v,
    input wire logic                settling,
    input adc_ctl_pkg::pwr_mode_t   pwr_mode,
    input adc_ctl_pkg::if_mode_t    if_mode,
    input wire logic                hold_lo_half,
    input wire logic                hold_hi_half,
    input wire logic                busy,
    input wire logic [DATA_W-1:0]   db_oe_b,
    input wire logic                dout_oe_b
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // A start counts only when idle and powered; sync lag is up to 4.
    sequence lo_rise_s;
        $rose(conv_start_lo_half) && !busy && !hold_lo_half
            && pwr_mode == PWR_NORMAL && !reset_pin;
    endsequence
    sequence busy_rise_s;
        $rose(busy);
    endsequence

    range_hi_a: assert property (range_pin[*4] |-> range_10v)
        else $error("range_10v low with span input high");
    range_lo_a: assert property (!range_pin[*4] |-> !range_10v)
        else $error("range_10v high with span input low");
    settle_flag_a: assert property (
        $changed(range_10v) |-> ##[0:2] settling)
        else $error("settling not raised after span change");
    pwr_normal_a: assert property (
        power_down_n[*4] |-> pwr_mode == PWR_NORMAL)
        else $error("power mode not normal while powered");
    pwr_power_down_n_a: assert property (
        (!power_down_n && !range_pin)[*4] |-> pwr_mode == PWR_STANDBY)
        else $error("standby not entered");
    pwr_shut_a: assert property (
        (!power_down_n && range_pin)[*4] |-> pwr_mode == PWR_SHUTDOWN)
        else $error("shutdown not entered");
    mode_par_a: assert property (
        !interface_select[*4] |-> if_mode == IF_PARALLEL)
        else $error("parallel mode not selected");
    lo_hold_a: assert property (lo_rise_s |-> ##[2:4] hold_lo_half)
        else $error("low half not placed in hold");
    busy_hold_a: assert property (
        $rose(busy) |-> hold_lo_half && hold_hi_half)
        else $error("busy without both halves held");
    busy_span_a: assert property (
        busy_rise_s |=> busy[*4] ##[1:260] !busy)
        else $error("busy span out of bounds");
    cs_float_a: assert property (
        chip_select_b[*4] |-> db_oe_b == 16'hFFFF && dout_oe_b)
        else $error("outputs driven while deselected");
    par_drive_a: assert property (
        !db_oe_b[0] |-> if_mode != IF_SERIAL && !$past(chip_select_b, 3)
            && !$past(rd_b_or_sclk, 3))
        else $error("bus driven without select and strobe");
    pin_reset_a: assert property (
        reset_pin[*4] |-> !busy && !hold_lo_half && !hold_hi_half)
        else $error("conversion state kept during reset");
endmodule : adc_ctl_checker

bind adc_control_pin_logic adc_ctl_checker chk (.*);

// ---- adc_ctl_pkg.sv ----
// Shared constants and types for the converter control-pin logic.
package adc_ctl_pkg;
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned CONV_TIME_NS    = 2000;
    localparam int unsigned CONV_CYCLES     = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_TIME_US  = 80;
    localparam int unsigned SETTLE_CYCLES   =
        (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned NUM_CH          = 8;
    localparam int unsigned HALF_CH         = 4;
    localparam int unsigned DATA_W          = 16;
    localparam int unsigned BITS_PER_CH     = 16;
    localparam logic [15:0] DATA_RESET      = 16'h0000;
    localparam logic [2:0]  CH_FIRST        = 3'h0;
    localparam logic [2:0]  CH_LAST         = 3'h7;
    localparam logic [3:0]  BIT_LAST        = 4'hF;
    localparam logic        BYTE_FIRST      = 1'b0;
    localparam int unsigned CNT_W           = 16;

    typedef enum logic [1:0] {
        IF_PARALLEL,
        IF_SERIAL,
        IF_BYTE
    } if_mode_t;

    typedef enum logic [1:0] {
        PWR_NORMAL,
        PWR_STANDBY,
        PWR_SHUTDOWN
    } pwr_mode_t;
endpackage : adc_ctl_pkg

// ---- conv_timer.sv ----
// Conversion timer for one half of the channel set.
`timescale 1ns/1ps
module conv_timer
    import adc_ctl_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic abort,
    input  wire logic start,
    output logic      running,
    output logic      done
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             run;
        logic             done;
    } tmr_state_t;

    tmr_state_t st_ff;
    tmr_state_t nxt_st;

    // Counts the internal conversion time; an abort drops it at once.
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;
        if (abort) begin
            nxt_st.run = 1'b0;
            nxt_st.cnt = '0;
        end else if (start && !st_ff.run) begin
            nxt_st.run = 1'b1;
            nxt_st.cnt = CNT_W'(CONV_CYCLES - 1);
        end else if (st_ff.run) begin
            if (st_ff.cnt == '0) begin
                nxt_st.run  = 1'b0;
                nxt_st.done = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign running = st_ff.run;
    assign done    = st_ff.done;
endmodule : conv_timer

// ---- host_model.sv ----
// Host controller model that drives the converter control pins.
`timescale 1ns/1ps
module host_model (
    input  wire logic clk,
    input  wire logic busy,
    output logic      reset_pin,
    output logic      range_pin,
    output logic      power_down_n,
    output logic      interface_select,
    output logic      bit15_or_byte_select_in,
    output logic      conv_start_lo_half,
    output logic      conv_start_hi_half,
    output logic      chip_select_b,
    output logic      rd_b_or_sclk
);
    // ****************************************
    // Pin drivers
    // ****************************************
    // Idle levels; strobe and serial clock rest high outside frames.
    // span fixed between calls
    initial begin
        reset_pin = 1'b0;
        range_pin = 1'b0;
        power_down_n = 1'b1;
        interface_select = 1'b0;
        bit15_or_byte_select_in = 1'b0;
        conv_start_lo_half = 1'b0;
        conv_start_hi_half = 1'b0;
        chip_select_b = 1'b1;
        rd_b_or_sclk = 1'b1;
    end

    // Every action waits past the two-flop sync and output register.
    task automatic settle();
        repeat (6) @(negedge clk);
    endtask : settle

    task automatic set_cfg(input logic r, input logic p, input logic i,
                           input logic b);
        @(negedge clk);
        range_pin = r;
        power_down_n = p;
        interface_select = i;
        bit15_or_byte_select_in = b;
        settle();
    endtask : set_cfg

    // starts tied or lowered once idle
    task automatic set_start(input logic lo, input logic hi);
        @(negedge clk);
        conv_start_lo_half = lo;
        conv_start_hi_half = hi;
        settle();
    endtask : set_start

    task automatic set_rd(input logic cs, input logic rd);
        @(negedge clk);
        chip_select_b = cs;
        rd_b_or_sclk = rd;
        settle();
    endtask : set_rd

    // One serial clock period at the link rate, phase unrelated to clk.
    // rising edge advances
    task automatic sclk_rise();
        #62.5 rd_b_or_sclk = 1'b0;
        #62.5 rd_b_or_sclk = 1'b1;
        settle();
    endtask : sclk_rise

    // pulse, then gap before next start
    task automatic pulse_reset();
        @(negedge clk);
        reset_pin = 1'b1;
        repeat (5) @(negedge clk);
        reset_pin = 1'b0;
        repeat (8) @(negedge clk);
    endtask : pulse_reset

    // Bounded wait for the end of a conversion.
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 400) begin
            @(negedge clk);
            n++;
        end
        settle();
    endtask : wait_idle
endmodule : host_model

// ---- sync2.sv ----
// Two-flop synchroniser for one asynchronous level.
`timescale 1ns/1ps
module sync2 #(parameter logic RST_VAL = 1'b0) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic d,
    output logic      q
);
    typedef struct packed {
        logic meta;
        logic hold;
    } sync_state_t;

    sync_state_t st_ff;
    sync_state_t nxt_st;

    // The first stage is read only by the second stage.
    always_comb begin
        nxt_st.meta = d;
        nxt_st.hold = st_ff.meta;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '{meta: RST_VAL, hold: RST_VAL};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign q = st_ff.hold;
endmodule : sync2

// ---- tb_top.sv ----
// Self-checking bench for the converter control-pin logic.
`timescale 1ns/1ps
module tb_top;
    import adc_ctl_pkg::*;
    logic                       clk, rst_b, msb_byte_first;
    logic                       reset_pin, range_pin, power_down_n;
    logic                       interface_select, bit15_or_byte_select_in;
    logic                       conv_start_lo_half, conv_start_hi_half;
    logic                       chip_select_b, rd_b_or_sclk;
    logic [NUM_CH*DATA_W-1:0]   sample_data;
    logic                       range_10v, settling, busy, data_invalid;
    logic                       hold_lo_half, hold_hi_half;
    logic                       dout_a, dout_b, dout_oe_b;
    logic [DATA_W-1:0]          db_out, db_oe_b;
    pwr_mode_t                  pwr_mode;
    if_mode_t                   if_mode;
    int                         mismatches, total_checks;

    adc_control_pin_logic uut (.*);
    host_model host (.*);

    // ****************************************
    // Clock, reset and helpers
    // ****************************************
    initial clk = 1'b0;
    always #5 clk = ~clk;

    // Channel values carry distinct top bits so serial order shows.
    function automatic logic [15:0] exp_ch(input int c);
        return 16'(16'h1111 * c) | (c < 4 ? 16'h8000 : 16'h0000);
    endfunction : exp_ch

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_range();
        host.set_cfg(1'b1, 1'b1, 1'b0, 1'b0);
        check("range_10v", 16'h0001, 16'(range_10v));
        check("settling", 16'h0001, 16'(settling));
        host.set_cfg(1'b0, 1'b1, 1'b0, 1'b0);
        check("range_10v", 16'h0000, 16'(range_10v));
    endtask : t_range

    task automatic t_power();
        for (int r = 0; r < 2; r++) begin
            host.set_cfg(1'(r), 1'b0, 1'b0, 1'b0);
            check("pwr_mode", r ? 16'(PWR_SHUTDOWN) : 16'(PWR_STANDBY),
                  16'(pwr_mode));
        end
        host.set_cfg(1'b0, 1'b1, 1'b0, 1'b0);
        check("pwr_mode", 16'(PWR_NORMAL), 16'(pwr_mode));
        host.pulse_reset();
    endtask : t_power

    task automatic t_modes();
        logic [1:0] sel [3] = '{2'h0, 2'h2, 2'h3};
        if_mode_t   want [3] = '{IF_PARALLEL, IF_SERIAL, IF_BYTE};
        for (int k = 0; k < 3; k++) begin
            host.set_cfg(1'b0, 1'b1, sel[k][1], sel[k][0]);
            check("if_mode", 16'(want[k]), 16'(if_mode));
        end
        host.set_cfg(1'b0, 1'b1, 1'b0, 1'b0);
    endtask : t_modes

    // Staggered halves, then a parallel read with starts still high.
    task automatic t_conv();
        host.set_start(1'b1, 1'b0);
        check("hold_lo", 16'h0001, 16'(hold_lo_half));
        check("hold_hi", 16'h0000, 16'(hold_hi_half));
        host.set_start(1'b1, 1'b1);
        check("busy", 16'h0001, 16'(busy));
        host.set_start(1'b0, 1'b1);
        host.set_start(1'b1, 1'b1);
        host.wait_idle();
        check("busy", 16'h0000, 16'(busy));
        host.set_rd(1'b0, 1'b0);
        check("db_oe_b", 16'h0000, db_oe_b);
        check("db_out", exp_ch(0), db_out);
        host.set_rd(1'b0, 1'b1);
        host.set_rd(1'b0, 1'b0);
        check("db_out", exp_ch(1), db_out);
        host.set_rd(1'b1, 1'b1);
        check("db_oe_b", 16'hFFFF, db_oe_b);
        host.set_start(1'b0, 1'b0);
    endtask : t_conv

    task automatic t_serial();
        host.set_start(1'b1, 1'b1);
        host.wait_idle();
        host.set_start(1'b0, 1'b0);
        host.set_cfg(1'b0, 1'b1, 1'b1, 1'b0);
        host.set_rd(1'b0, 1'b1);
        check("dout_oe_b", 16'h0000, 16'(dout_oe_b));
        check("dout_a", exp_ch(0) >> 15, 16'(dout_a));
        check("dout_b", exp_ch(4) >> 15, 16'(dout_b));
        host.sclk_rise();
        check("dout_a", (exp_ch(0) >> 14) & 16'h0001,
              16'(dout_a));
        check("dout_b", (exp_ch(4) >> 14) & 16'h0001,
              16'(dout_b));
        host.set_rd(1'b1, 1'b1);
        check("dout_oe_b", 16'h0001, 16'(dout_oe_b));
        // Byte mode with the low byte first, then the high byte.
        host.set_cfg(1'b0, 1'b1, 1'b1, 1'b1);
        host.set_rd(1'b0, 1'b0);
        check("db_out", exp_ch(0) & 16'h00FF, db_out);
        host.set_rd(1'b0, 1'b1);
        host.set_rd(1'b0, 1'b0);
        check("db_out", exp_ch(0) >> 8, db_out);
        host.set_rd(1'b1, 1'b1);
        host.set_cfg(1'b0, 1'b1, 1'b0, 1'b0);
    endtask : t_serial

    task automatic t_abort();
        host.set_start(1'b1, 1'b1);
        host.pulse_reset();
        check("busy", 16'h0000, 16'(busy));
        check("data_invalid", 16'h0001, 16'(data_invalid));
        host.set_start(1'b0, 1'b0);
    endtask : t_abort

    task automatic t_rdreset();
        host.set_start(1'b1, 1'b1);
        host.wait_idle();
        host.set_start(1'b0, 1'b0);
        host.set_rd(1'b0, 1'b0);
        check("db_out", exp_ch(0), db_out);
        host.pulse_reset();
        check("db_out", DATA_RESET, db_out);
        host.set_rd(1'b1, 1'b1);
    endtask : t_rdreset

    // ****************************************
    // Main sequence and watchdog
    // ****************************************
    initial begin
        rst_b = 1'b0;
        msb_byte_first = 1'b0;
        mismatches = 0;
        total_checks = 0;
        for (int c = 0; c < NUM_CH; c++) begin
            sample_data[16*c +: 16] = exp_ch(c);
        end
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        host.pulse_reset();
        t_range();
        t_power();
        t_modes();
        t_conv();
        t_serial();
        t_abort();
        t_rdreset();
        conclude();
    end

    // The run needs under a thousand cycles; this bound is generous.
    initial begin
        #200000;
        mismatches++;
        conclude();
    end
endmodule : tb_top
